// File: rtl/dru_pkg.sv
// Constants, types and helpers for the DMA channel register-update block.
// Assumes one 40 MHz bus clock; every user writes dru_pkg::name explicitly.
// How it works
// - Source update field: fixed, offset, increment, decrement.
// - Destination update field uses the same encoding.
// - Element size gives byte, word, longword steps.
// - Drive current source address, then advance it.
// - Unaligned source element splits into smaller reads.
// - Unaligned destination element splits into smaller writes.
// - Block end returns source area to start unless rep_dst is set.
// - Block end returns destination area to start when rep_dst is set.
// - Extended area keeps upper address bits fixed.
// - Byte count drops by element bytes.
// - Zero byte count means uncounted, left unchanged.
// - CPU write wins; nonzero count clash stops.
// - Upper half reload size, lower half counter.
// - Counter reloads instead of reaching zero.
// - Enable clears on done, escape, fault, write.
// - Active is low while idle or waiting.
// - Block finishes; burst allows two more elements after the one in flight.
// - Fault clears enable and sets fault flag.
// - Escape causes set escape flag as active drops.
// - Count completion sets done flag as active drops.
// - Re-enabling clears escape flag and held request.
// - Re-enabling clears done flag and held request.
// - Offset mode adds signed offset per element.
// - Enabled area overflow sets escape and stops.
package dru_pkg;
	// Register byte addresses.
	localparam logic [4:0] OFF_SRC = 5'h00;
	localparam logic [4:0] OFF_DST = 5'h04;
	localparam logic [4:0] OFF_CNT = 5'h08;
	localparam logic [4:0] OFF_BLK = 5'h0C;
	localparam logic [4:0] OFF_MODE = 5'h10;
	localparam logic [4:0] OFF_CTRL = 5'h14;
	localparam logic [4:0] OFF_OFS = 5'h18;
	// Mode register bit positions.
	localparam int MODE_EN = 0;
	localparam int MODE_ACTIVE = 1;
	localparam int MODE_FAULT = 2;
	localparam int MODE_ESC = 3;
	localparam int MODE_ESC_IE = 4;
	localparam int MODE_DONE = 5;
	localparam int MODE_DONE_IE = 6;
	localparam int MODE_ESZ = 8;
	localparam int MODE_TMODE = 12;
	localparam int MODE_BURST = 14;
	// Address control register bit positions.
	localparam int CTRL_SUT = 0;
	localparam int CTRL_DUT = 2;
	localparam int CTRL_REP_DST = 4;
	localparam int CTRL_SAREA = 8;
	localparam int CTRL_DAREA = 16;
	localparam int CTRL_SIE = 24;
	localparam int CTRL_DIE = 25;
	// Burst elements still allowed after enable is written low.
	localparam logic [1:0] TAIL_MAX = 2'h3;
	localparam logic [15:0] BLK_LAST = 16'h0001;
	typedef enum logic [1:0] {DRU_IDLE = 2'h0, DRU_READ = 2'h1, DRU_WRITE = 2'h3} dru_fsm_e;
	typedef enum logic [1:0] {UPD_FIXED = 2'h0, UPD_OFS = 2'h1, UPD_INC = 2'h2, UPD_DEC = 2'h3} dru_upd_e;
	typedef enum logic [1:0] {TM_NORMAL = 2'h0, TM_REPEAT = 2'h1, TM_BLOCK = 2'h2} dru_tmode_e;
	// Element size code to byte count; the spare code acts as byte.
	function automatic logic [2:0] elem_bytes(input logic [1:0] esz);
		if (esz == 2'h1)
			return 3'h2;
		else if (esz == 2'h2)
			return 3'h4;
		else
			return 3'h1;
	endfunction
endpackage

// File: rtl/dru_step_if.sv
// Interface between the channel and one address-step calculator.
// Assumes the calculator is purely combinational.
`timescale 1ns/1ps
interface dru_step_if;
	logic [31:0] cur;
	logic [1:0] sel;
	logic [1:0] esz;
	logic [31:0] ofs;
	logic [4:0] area;
	logic [31:0] next;
	logic ovf;
	modport calc (input cur, input sel, input esz, input ofs, input area, output next, output ovf);
	modport user (output cur, output sel, output esz, output ofs, output area, input next, input ovf);
endinterface

// File: rtl/dru_addr_step.sv
// Next-address calculator for one side of the channel.
// Assumes cur is the address at which the element started.
`timescale 1ns/1ps
module dru_addr_step
(
	dru_step_if.calc sp
);
	logic [31:0] step32;
	logic [31:0] raw;
	logic [31:0] mask;

	// Area size zero means no extended area, so the mask opens every bit.
	always_comb
	begin
		step32 = {29'h0000_000, dru_pkg::elem_bytes(sp.esz)};
		case (sp.sel)
			dru_pkg::UPD_FIXED: raw = sp.cur;
			dru_pkg::UPD_OFS: raw = sp.cur + sp.ofs;
			dru_pkg::UPD_INC: raw = sp.cur + step32;
			default: raw = sp.cur - step32;
		endcase
		mask = (sp.area == 5'h00) ? 32'hFFFF_FFFF : ((32'h0000_0001 << sp.area) - 32'h0000_0001);
		sp.next = (sp.cur & ~mask) | (raw & mask);
		// Overflow is the carry or borrow out of the area.
		sp.ovf = (sp.area != 5'h00) && (sp.sel != dru_pkg::UPD_FIXED) &&
			((raw & ~mask) != (sp.cur & ~mask));
	end
endmodule

// File: rtl/dru_channel.sv
// One DMA channel: address, count and block registers with their status flags.
// Assumes a bus controller that holds bus_done low until a piece completes,
// and a CPU port with single-cycle strobes and read data one cycle later.
`timescale 1ns/1ps
module dru_channel
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [4:0] addr,
	input wire logic [31:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [31:0] rd_data,
	input wire logic xfer_req,
	input wire logic size_err,
	input wire logic fault_in,
	input wire logic bus_done,
	output logic bus_req,
	output logic bus_wr,
	output logic [31:0] bus_addr,
	output logic [2:0] bus_len,
	output logic active,
	output logic esc_irq,
	output logic done_irq
);
	typedef struct packed {
		logic [31:0] src;
		logic [31:0] dst;
		logic [31:0] cnt;
		logic [15:0] blk_reload;
		logic [15:0] blk_cnt;
		logic [31:0] ofs;
		logic en;
		logic fault;
		logic esc;
		logic esc_ie;
		logic done;
		logic done_ie;
		logic [1:0] esz;
		logic [1:0] tmode;
		logic burst;
		logic [1:0] sut;
		logic [1:0] dut;
		logic rep_dst;
		logic [4:0] sarea;
		logic [4:0] darea;
		logic sie;
		logic die;
		dru_pkg::dru_fsm_e fsm;
		logic [31:0] src_start;
		logic [31:0] dst_start;
		logic [31:0] src_base;
		logic [31:0] dst_base;
		logic [2:0] pdone;
		logic [1:0] tail;
		logic tail_live;
		logic blk_run;
		logic err_pend;
		logic active;
		logic [31:0] rdata;
		logic bus_req;
		logic bus_wr;
		logic [31:0] bus_addr;
		logic [2:0] bus_len;
		logic esc_irq;
		logic done_irq;
	} dru_state_s;

	dru_state_s st;
	dru_state_s nx;
	logic rst_meta;
	logic rst_n_sync;
	logic [2:0] bytes;
	logic [2:0] psum;
	logic [31:0] naddr;
	logic elem_end;
	logic hw_stop;
	logic set_esc;
	logic set_done;
	logic blk_end;
	logic start;
	logic [31:0] rmux;
	dru_step_if src_sp ();
	dru_step_if dst_sp ();

	// Both calculators work from the element start, so pieces never disturb them.
	dru_addr_step u_src_step (.sp(src_sp.calc));
	dru_addr_step u_dst_step (.sp(dst_sp.calc));
	assign src_sp.cur = st.src_start;
	assign src_sp.sel = st.sut;
	assign src_sp.esz = st.esz;
	assign src_sp.ofs = st.ofs;
	assign src_sp.area = st.sarea;
	assign dst_sp.cur = st.dst_start;
	assign dst_sp.sel = st.dut;
	assign dst_sp.esz = st.esz;
	assign dst_sp.ofs = st.ofs;
	assign dst_sp.area = st.darea;

	// Largest aligned bus piece that still fits in the rest of the element.
	function automatic logic [2:0] piece_len(input logic [31:0] a, input logic [2:0] rem);
		if (rem >= 3'h4 && a[1:0] == 2'h0)
			return 3'h4;
		else if (rem >= 3'h2 && a[0] == 1'b0)
			return 3'h2;
		else
			return 3'h1;
	endfunction

	// Register address compare, shared by the read mux and the write decode.
	function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
		return a == off;
	endfunction

	// Reset is released through two flops so release never races the clock.
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			rst_meta <= 1'b0;
			rst_n_sync <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n_sync <= rst_meta;
		end
	end

	// Read mux; unmapped addresses read as zero.
	always_comb
	begin
		rmux = 32'h0000_0000;
		if (hit(addr, dru_pkg::OFF_SRC))
			rmux = st.src;
		else if (hit(addr, dru_pkg::OFF_DST))
			rmux = st.dst;
		else if (hit(addr, dru_pkg::OFF_CNT))
			rmux = st.cnt;
		else if (hit(addr, dru_pkg::OFF_BLK))
			rmux = {st.blk_reload, st.blk_cnt};
		else if (hit(addr, dru_pkg::OFF_OFS))
			rmux = st.ofs;
		else if (hit(addr, dru_pkg::OFF_MODE))
		begin
			rmux[dru_pkg::MODE_EN] = st.en;
			rmux[dru_pkg::MODE_ACTIVE] = st.active;
			rmux[dru_pkg::MODE_FAULT] = st.fault;
			rmux[dru_pkg::MODE_ESC] = st.esc;
			rmux[dru_pkg::MODE_ESC_IE] = st.esc_ie;
			rmux[dru_pkg::MODE_DONE] = st.done;
			rmux[dru_pkg::MODE_DONE_IE] = st.done_ie;
			rmux[dru_pkg::MODE_ESZ +: 2] = st.esz;
			rmux[dru_pkg::MODE_TMODE +: 2] = st.tmode;
			rmux[dru_pkg::MODE_BURST] = st.burst;
		end
		else if (hit(addr, dru_pkg::OFF_CTRL))
		begin
			rmux[dru_pkg::CTRL_SUT +: 2] = st.sut;
			rmux[dru_pkg::CTRL_DUT +: 2] = st.dut;
			rmux[dru_pkg::CTRL_REP_DST] = st.rep_dst;
			rmux[dru_pkg::CTRL_SAREA +: 5] = st.sarea;
			rmux[dru_pkg::CTRL_DAREA +: 5] = st.darea;
			rmux[dru_pkg::CTRL_SIE] = st.sie;
			rmux[dru_pkg::CTRL_DIE] = st.die;
		end
	end

	// Whole next state: engine first, then CPU writes, then hardware flag events.
	always_comb
	begin
		nx = st;
		bytes = dru_pkg::elem_bytes(st.esz);
		psum = st.pdone + st.bus_len;
		naddr = 32'h0000_0000;
		elem_end = 1'b0;
		hw_stop = 1'b0;
		set_esc = 1'b0;
		set_done = 1'b0;
		blk_end = 1'b0;
		start = 1'b0;
		case (st.fsm)
			dru_pkg::DRU_IDLE:
			begin
				// Mid-block elements run without a request; a whole block ends unless a stop, a fault or a held size error cuts it short.
				start = !st.err_pend && (st.blk_run || (st.en && xfer_req) ||
					(st.tail_live && xfer_req && st.tail != dru_pkg::TAIL_MAX));
				if (st.err_pend && (st.en || st.tail_live))
				begin
					hw_stop = 1'b1;
					set_esc = 1'b1;
				end
				if (st.tail_live && !start)
					nx.tail_live = 1'b0;
				if (start)
				begin
					if (st.blk_cnt == st.blk_reload)
					begin
						nx.src_base = st.src;
						nx.dst_base = st.dst;
					end
					nx.src_start = st.src;
					nx.dst_start = st.dst;
					nx.pdone = 3'h0;
					nx.fsm = dru_pkg::DRU_READ;
					nx.bus_req = 1'b1;
					nx.bus_wr = 1'b0;
					nx.bus_addr = st.src;
					nx.bus_len = piece_len(st.src, bytes);
				end
			end
			dru_pkg::DRU_READ:
			begin
				if (bus_done)
				begin
					if (psum >= bytes)
					begin
						nx.src = src_sp.next;
						nx.pdone = 3'h0;
						nx.fsm = dru_pkg::DRU_WRITE;
						nx.bus_wr = 1'b1;
						nx.bus_addr = st.dst;
						nx.bus_len = piece_len(st.dst, bytes);
					end
					else
					begin
						naddr = st.src + {29'h0000_000, st.bus_len};
						nx.src = naddr;
						nx.pdone = psum;
						nx.bus_addr = naddr;
						nx.bus_len = piece_len(naddr, bytes - psum);
					end
				end
			end
			dru_pkg::DRU_WRITE:
			begin
				if (bus_done)
				begin
					if (psum >= bytes)
					begin
						nx.dst = dst_sp.next;
						nx.pdone = 3'h0;
						nx.fsm = dru_pkg::DRU_IDLE;
						nx.bus_req = 1'b0;
						nx.bus_wr = 1'b0;
						elem_end = 1'b1;
					end
					else
					begin
						naddr = st.dst + {29'h0000_000, st.bus_len};
						nx.dst = naddr;
						nx.pdone = psum;
						nx.bus_addr = naddr;
						nx.bus_len = piece_len(naddr, bytes - psum);
					end
				end
			end
			default: nx.fsm = dru_pkg::DRU_IDLE;
		endcase
		// End of one element: count, block counter and stop causes.
		if (elem_end)
		begin
			if (st.cnt != 32'h0000_0000)
			begin
				nx.cnt = st.cnt - {29'h0000_000, bytes};
				if (nx.cnt == 32'h0000_0000)
				begin
					hw_stop = 1'b1;
					set_done = 1'b1;
				end
			end
			if (st.tmode != dru_pkg::TM_NORMAL)
			begin
				if (st.blk_cnt == dru_pkg::BLK_LAST)
				begin
					nx.blk_cnt = st.blk_reload;
					blk_end = 1'b1;
				end
				else
					nx.blk_cnt = st.blk_cnt - dru_pkg::BLK_LAST;
			end
			if (blk_end && st.rep_dst)
				nx.dst = st.dst_base;
			else if (blk_end)
				nx.src = st.src_base;
			if (blk_end && st.tmode == dru_pkg::TM_REPEAT)
			begin
				hw_stop = 1'b1;
				set_esc = 1'b1;
			end
			nx.blk_run = (st.tmode == dru_pkg::TM_BLOCK) && !blk_end;
			if ((src_sp.ovf && st.sie) || (dst_sp.ovf && st.die) || st.err_pend)
			begin
				hw_stop = 1'b1;
				set_esc = 1'b1;
			end
			if (st.tail_live)
				nx.tail = st.tail + 2'h1;
		end
		// CPU writes land after the engine, so they win any clash.
		if (wr_en)
		begin
			if (hit(addr, dru_pkg::OFF_SRC))
				nx.src = wr_data;
			else if (hit(addr, dru_pkg::OFF_DST))
				nx.dst = wr_data;
			else if (hit(addr, dru_pkg::OFF_CNT))
				nx.cnt = wr_data;
			else if (hit(addr, dru_pkg::OFF_BLK))
			begin
				nx.blk_reload = wr_data[31:16];
				nx.blk_cnt = wr_data[15:0];
			end
			else if (hit(addr, dru_pkg::OFF_OFS))
				nx.ofs = wr_data;
			else if (hit(addr, dru_pkg::OFF_MODE))
			begin
				nx.en = wr_data[dru_pkg::MODE_EN];
				if (wr_data[dru_pkg::MODE_EN] && !st.en)
				begin
					nx.esc = 1'b0;
					nx.done = 1'b0;
					nx.err_pend = 1'b0;
				end
				else
				begin
					nx.esc = st.esc & wr_data[dru_pkg::MODE_ESC];
					nx.done = st.done & wr_data[dru_pkg::MODE_DONE];
				end
				nx.fault = st.fault & wr_data[dru_pkg::MODE_FAULT];
				// A burst stopped by software may still run a few more elements.
				if (!wr_data[dru_pkg::MODE_EN] && st.en && st.burst && st.fsm != dru_pkg::DRU_IDLE)
				begin
					nx.tail_live = 1'b1;
					nx.tail = 2'h0;
				end
				nx.esc_ie = wr_data[dru_pkg::MODE_ESC_IE];
				nx.done_ie = wr_data[dru_pkg::MODE_DONE_IE];
				nx.esz = wr_data[dru_pkg::MODE_ESZ +: 2];
				nx.tmode = wr_data[dru_pkg::MODE_TMODE +: 2];
				nx.burst = wr_data[dru_pkg::MODE_BURST];
			end
			else if (hit(addr, dru_pkg::OFF_CTRL))
			begin
				nx.sut = wr_data[dru_pkg::CTRL_SUT +: 2];
				nx.dut = wr_data[dru_pkg::CTRL_DUT +: 2];
				nx.rep_dst = wr_data[dru_pkg::CTRL_REP_DST];
				nx.sarea = wr_data[dru_pkg::CTRL_SAREA +: 5];
				nx.darea = wr_data[dru_pkg::CTRL_DAREA +: 5];
				nx.sie = wr_data[dru_pkg::CTRL_SIE];
				nx.die = wr_data[dru_pkg::CTRL_DIE];
			end
		end
		// Hardware stops and flag sets come last, so a set beats a clear.
		if (hw_stop)
		begin
			nx.en = 1'b0;
			nx.blk_run = 1'b0;
			nx.tail_live = 1'b0;
			nx.err_pend = 1'b0;
		end
		// A size error in the same cycle as a clear or a stop stays latched, so it is never lost.
		if (size_err)
			nx.err_pend = 1'b1;
		if (fault_in)
		begin
			nx.en = 1'b0;
			nx.fault = 1'b1;
			nx.fsm = dru_pkg::DRU_IDLE;
			nx.bus_req = 1'b0;
			nx.bus_wr = 1'b0;
			nx.blk_run = 1'b0;
			nx.tail_live = 1'b0;
		end
		if (set_esc)
			nx.esc = 1'b1;
		if (set_done)
			nx.done = 1'b1;
		nx.active = (nx.fsm != dru_pkg::DRU_IDLE) || nx.blk_run || nx.tail_live;
		nx.esc_irq = nx.esc & nx.esc_ie;
		nx.done_irq = nx.done & nx.done_ie;
		nx.rdata = rd_en ? rmux : 32'h0000_0000;
	end

	// Single state register; everything clears on reset.
	always_ff @(posedge clk_sys or negedge rst_n_sync)
	begin
		if (!rst_n_sync)
			st <= '0;
		else
			st <= nx;
	end

	assign rd_data = st.rdata;
	assign bus_req = st.bus_req;
	assign bus_wr = st.bus_wr;
	assign bus_addr = st.bus_addr;
	assign bus_len = st.bus_len;
	assign active = st.active;
	assign esc_irq = st.esc_irq;
	assign done_irq = st.done_irq;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n_sync);

	// Checks on the register updates and flags.
	cnt_step_a: assert property (
		elem_end && st.cnt != 32'h0000_0000 && !wr_en |=>
		st.cnt == $past(st.cnt) - {29'h0000_000, $past(bytes)}) else $error("count step wrong");
	cnt_free_a: assert property (
		elem_end && st.cnt == 32'h0000_0000 && !wr_en |=> st.cnt == 32'h0000_0000)
		else $error("free count changed");
	blk_reload_a: assert property (
		elem_end && st.tmode != dru_pkg::TM_NORMAL && st.blk_cnt == dru_pkg::BLK_LAST && !wr_en
		|=> st.blk_cnt == $past(st.blk_reload)) else $error("block counter not reloaded");
	blk_dec_a: assert property (
		elem_end && st.tmode != dru_pkg::TM_NORMAL && st.blk_cnt > dru_pkg::BLK_LAST && !wr_en
		|=> st.blk_cnt == $past(st.blk_cnt) - dru_pkg::BLK_LAST) else $error("block count wrong");
	src_inc_a: assert property (
		st.fsm == dru_pkg::DRU_READ && bus_done && psum >= bytes && !wr_en && !fault_in &&
		st.sut == dru_pkg::UPD_INC && st.sarea == 5'h00
		|=> st.src == $past(st.src_start) + {29'h0000_000, $past(bytes)}) else $error("source step");
	fault_stop_a: assert property (
		fault_in |=> !st.en && st.fault && !bus_req ##1 !active) else $error("fault did not stop");
	done_flag_a: assert property (
		set_done |=> st.done && !st.en ##1 !active) else $error("done flag or stop missing");
	irq_follow_a: assert property (
		st.esc && st.esc_ie ##1 st.esc && st.esc_ie |-> esc_irq) else $error("escape irq low");
	resume_clear_a: assert property (
		wr_en && hit(addr, dru_pkg::OFF_MODE) && wr_data[dru_pkg::MODE_EN] && !st.en && st.esc &&
		!set_esc |=> !st.esc) else $error("escape flag not cleared on resume");
	idle_low_a: assert property (
		st.fsm == dru_pkg::DRU_IDLE && !st.blk_run && !st.tail_live ##1
		st.fsm == dru_pkg::DRU_IDLE && !st.blk_run && !st.tail_live |-> !active)
		else $error("active high while idle");
	cpu_wins_a: assert property (
		wr_en && hit(addr, dru_pkg::OFF_CNT) |=> st.cnt == $past(wr_data))
		else $error("count write lost");
	reload_c: cover property (elem_end && blk_end);
	overflow_c: cover property (elem_end && set_esc && (src_sp.ovf || dst_sp.ovf));
	count_done_c: cover property (set_done ##[1:3] done_irq);
endmodule

// File: tb/tb_bus_partner.sv
// Bus controller model that completes each piece the channel requests.
// Assumes the channel holds bus_req and its qualifiers until bus_done.
`timescale 1ns/1ps
module tb_bus_partner
(
	input wire logic clk_sys,
	input wire logic bus_req,
	input wire logic bus_wr,
	input wire logic [2:0] bus_len,
	input wire logic [3:0] lat,
	output logic bus_done,
	output int rd_pieces,
	output int wr_pieces,
	output int rd_bytes
);
	logic [3:0] wait_cnt = 4'h0;

	// A piece ends lat cycles after it is first seen, with a one-cycle pulse.
	// The wait restarts after each pulse, so a piece is never acknowledged twice.
	always @(posedge clk_sys)
	begin
		if (bus_done)
		begin
			bus_done <= 1'b0;
			wait_cnt <= 4'h0;
		end
		else if (bus_req)
		begin
			if (wait_cnt == lat)
			begin
				bus_done <= 1'b1;
				if (bus_wr)
					wr_pieces <= wr_pieces + 1;
				else
					rd_pieces <= rd_pieces + 1;
				if (!bus_wr)
					rd_bytes <= rd_bytes + int'(bus_len);
			end
			else
				wait_cnt <= wait_cnt + 4'h1;
		end
	end

	initial bus_done = 1'b0;
endmodule

// File: tb/testbench.sv
// Self-checking bench for the channel register-update block.
// Assumes the partner model acknowledges every bus piece it is handed.
`timescale 1ns/1ps
module testbench;
	logic clk_sys;
	logic nrst;
	logic [4:0] addr;
	logic [31:0] wr_data;
	logic wr_en;
	logic rd_en;
	logic [31:0] rd_data;
	logic xfer_req;
	logic size_err;
	logic fault_in;
	logic bus_done;
	logic bus_req;
	logic bus_wr;
	logic [31:0] bus_addr;
	logic [2:0] bus_len;
	logic active;
	logic esc_irq;
	logic done_irq;
	logic [3:0] lat;
	int rd_pieces;
	int wr_pieces;
	int rd_bytes;
	int error_cnt = 0;
	int cmp_count = 0;

	dru_channel dru_channel_inst (.clk_sys(clk_sys), .nrst(nrst), .addr(addr),
		.wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
		.xfer_req(xfer_req), .size_err(size_err), .fault_in(fault_in),
		.bus_done(bus_done), .bus_req(bus_req), .bus_wr(bus_wr), .bus_addr(bus_addr),
		.bus_len(bus_len), .active(active), .esc_irq(esc_irq), .done_irq(done_irq));

	tb_bus_partner tb_bus_partner_inst (.clk_sys(clk_sys), .bus_req(bus_req),
		.bus_wr(bus_wr), .bus_len(bus_len), .lat(lat), .bus_done(bus_done),
		.rd_pieces(rd_pieces), .wr_pieces(wr_pieces), .rd_bytes(rd_bytes));

	// Free-running 40 MHz clock.
	initial
	begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic reg_wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk_sys);
		wr_en <= 1'b0;
	endtask

	// Read data is only valid in the cycle after the strobe, so sample it there.
	task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
		@(posedge clk_sys);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk_sys);
		rd_en <= 1'b0;
		#1;
		chk(rd_data, exp);
	endtask

	// Requests until the first piece shows, checks where it goes, then waits for idle.
	// Outputs are looked at 1 ns after the edge, once the registers have settled.
	task automatic run_elem(input logic [31:0] first_addr);
		int n;
		n = 0;
		xfer_req <= 1'b1;
		do
		begin
			@(posedge clk_sys);
			#1;
			n++;
		end while (bus_req !== 1'b1 && n < 20);
		xfer_req <= 1'b0;
		chk({31'h0, active}, 32'h1);
		chk(bus_addr, first_addr);
		n = 0;
		do
		begin
			@(posedge clk_sys);
			#1;
			n++;
		end while ((bus_req !== 1'b0 || active !== 1'b0) && n < 200);
		chk({31'h0, n < 200}, 32'h1);
	endtask

	task automatic t_regs;
		reg_wr(dru_pkg::OFF_SRC, 32'hA5A5_0001);
		reg_wr(dru_pkg::OFF_DST, 32'h5A5A_0002);
		reg_wr(dru_pkg::OFF_BLK, 32'h0004_0004);
		rd_chk(dru_pkg::OFF_SRC, 32'hA5A5_0001);
		rd_chk(dru_pkg::OFF_DST, 32'h5A5A_0002);
		rd_chk(dru_pkg::OFF_BLK, 32'h0004_0004);
		rd_chk(5'h1C, 32'h0000_0000);
	endtask

	// Unaligned word with slow acknowledges, ending the whole count.
	task automatic t_unaligned;
		int r0;
		int w0;
		int b0;
		r0 = rd_pieces;
		w0 = wr_pieces;
		b0 = rd_bytes;
		lat <= 4'h3;
		reg_wr(dru_pkg::OFF_CTRL, 32'h0000_000A);
		reg_wr(dru_pkg::OFF_SRC, 32'h0000_0101);
		reg_wr(dru_pkg::OFF_DST, 32'h0000_0200);
		reg_wr(dru_pkg::OFF_CNT, 32'h0000_0002);
		reg_wr(dru_pkg::OFF_MODE, 32'h0000_0141);
		run_elem(32'h0000_0101);
		chk(rd_pieces - r0, 32'h2);
		chk(rd_bytes - b0, 32'h2);
		chk(wr_pieces - w0, 32'h1);
		rd_chk(dru_pkg::OFF_SRC, 32'h0000_0103);
		rd_chk(dru_pkg::OFF_DST, 32'h0000_0202);
		rd_chk(dru_pkg::OFF_CNT, 32'h0000_0000);
		rd_chk(dru_pkg::OFF_MODE, 32'h0000_0160);
		chk({31'h0, done_irq}, 32'h1);
		reg_wr(dru_pkg::OFF_CNT, 32'h0000_0004);
		reg_wr(dru_pkg::OFF_MODE, 32'h0000_0141);
		rd_chk(dru_pkg::OFF_MODE, 32'h0000_0141);
		chk({31'h0, done_irq}, 32'h0);
		reg_wr(dru_pkg::OFF_MODE, 32'h0000_0000);
		lat <= 4'h0;
	endtask

	// Every element size against every update method on both sides.
	task automatic t_update;
		logic [31:0] step;
		logic [31:0] ofs;
		logic [31:0] d [4];
		ofs = 32'hFFFF_FFF0;
		for (int esz = 0; esz < 3; esz++)
		begin
			for (int sel = 0; sel < 4; sel++)
			begin
				step = 32'h1 << esz;
				d[0] = 32'h0;
				d[1] = ofs;
				d[2] = step;
				d[3] = -step;
				reg_wr(dru_pkg::OFF_CTRL, 32'(sel) | (32'(sel) << 2));
				reg_wr(dru_pkg::OFF_OFS, ofs);
				reg_wr(dru_pkg::OFF_SRC, 32'h0000_1000);
				reg_wr(dru_pkg::OFF_DST, 32'h0000_2000);
				reg_wr(dru_pkg::OFF_CNT, 32'h0000_0100);
				reg_wr(dru_pkg::OFF_MODE, 32'h1 | (32'(esz) << 8));
				run_elem(32'h0000_1000);
				rd_chk(dru_pkg::OFF_SRC, 32'h0000_1000 + d[sel]);
				rd_chk(dru_pkg::OFF_DST, 32'h0000_2000 + d[sel]);
				rd_chk(dru_pkg::OFF_CNT, 32'h0000_0100 - step);
				reg_wr(dru_pkg::OFF_MODE, 32'h0000_0000);
				rd_chk(dru_pkg::OFF_MODE, 32'h0000_0000);
			end
		end
	endtask

	// One three-element block, rewinding first the source then the destination.
	task automatic t_block;
		for (int side = 0; side < 2; side++)
		begin
			reg_wr(dru_pkg::OFF_CTRL, 32'h0000_000A | (32'(side) << 4));
			reg_wr(dru_pkg::OFF_SRC, 32'h0000_3000);
			reg_wr(dru_pkg::OFF_DST, 32'h0000_4000);
			reg_wr(dru_pkg::OFF_CNT, 32'h0000_0000);
			reg_wr(dru_pkg::OFF_BLK, 32'h0003_0003);
			reg_wr(dru_pkg::OFF_MODE, 32'h0000_2001);
			run_elem(32'h0000_3000);
			rd_chk(dru_pkg::OFF_SRC, side ? 32'h0000_3003 : 32'h0000_3000);
			rd_chk(dru_pkg::OFF_DST, side ? 32'h0000_4000 : 32'h0000_4003);
			rd_chk(dru_pkg::OFF_BLK, 32'h0003_0003);
			rd_chk(dru_pkg::OFF_CNT, 32'h0000_0000);
			reg_wr(dru_pkg::OFF_MODE, 32'h0000_0000);
		end
	endtask

	// Fault stops an armed channel; a size error escapes and re-enable clears it.
	task automatic t_events;
		reg_wr(dru_pkg::OFF_CNT, 32'h0000_0010);
		reg_wr(dru_pkg::OFF_MODE, 32'h0000_0001);
		fault_in <= 1'b1;
		@(posedge clk_sys);
		fault_in <= 1'b0;
		rd_chk(dru_pkg::OFF_MODE, 32'h0000_0004);
		reg_wr(dru_pkg::OFF_MODE, 32'h0000_0011);
		size_err <= 1'b1;
		@(posedge clk_sys);
		size_err <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rd_chk(dru_pkg::OFF_MODE, 32'h0000_0018);
		chk({31'h0, esc_irq}, 32'h1);
		reg_wr(dru_pkg::OFF_MODE, 32'h0000_0011);
		rd_chk(dru_pkg::OFF_MODE, 32'h0000_0011);
		chk({31'h0, esc_irq}, 32'h0);
		reg_wr(dru_pkg::OFF_MODE, 32'h0000_0000);
	endtask

	// Source area overflow escapes; a repeat end rewinds the source and escapes.
	task automatic t_wrap;
		reg_wr(dru_pkg::OFF_CTRL, 32'h0100_040A);
		reg_wr(dru_pkg::OFF_SRC, 32'h0000_050F);
		reg_wr(dru_pkg::OFF_DST, 32'h0000_0600);
		reg_wr(dru_pkg::OFF_CNT, 32'h0000_0000);
		reg_wr(dru_pkg::OFF_MODE, 32'h0000_0001);
		run_elem(32'h0000_050F);
		rd_chk(dru_pkg::OFF_SRC, 32'h0000_0500);
		rd_chk(dru_pkg::OFF_MODE, 32'h0000_0008);
		reg_wr(dru_pkg::OFF_CTRL, 32'h0000_000A);
		reg_wr(dru_pkg::OFF_SRC, 32'h0000_0700);
		reg_wr(dru_pkg::OFF_BLK, 32'h0002_0002);
		reg_wr(dru_pkg::OFF_MODE, 32'h0000_1001);
		run_elem(32'h0000_0700);
		run_elem(32'h0000_0701);
		rd_chk(dru_pkg::OFF_SRC, 32'h0000_0700);
		rd_chk(dru_pkg::OFF_DST, 32'h0000_0603);
		rd_chk(dru_pkg::OFF_BLK, 32'h0002_0002);
		rd_chk(dru_pkg::OFF_MODE, 32'h0000_1008);
		reg_wr(dru_pkg::OFF_MODE, 32'h0000_0000);
	endtask

	// Burst stopped mid-element: the element in flight and two more still run.
	task automatic t_burst;
		int n;
		lat <= 4'h3;
		reg_wr(dru_pkg::OFF_SRC, 32'h0000_0900);
		reg_wr(dru_pkg::OFF_CNT, 32'h0000_0100);
		reg_wr(dru_pkg::OFF_MODE, 32'h0000_4001);
		xfer_req <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk_sys);
			#1;
			n++;
		end while (bus_req !== 1'b1 && n < 20);
		reg_wr(dru_pkg::OFF_MODE, 32'h0000_4000);
		#1;
		chk({31'h0, active}, 32'h1);
		n = 0;
		do
		begin
			@(posedge clk_sys);
			#1;
			n++;
		end while (active !== 1'b0 && n < 200);
		xfer_req <= 1'b0;
		chk({31'h0, n < 200}, 32'h1);
		rd_chk(dru_pkg::OFF_CNT, 32'h0000_00FD);
		rd_chk(dru_pkg::OFF_SRC, 32'h0000_0903);
		rd_chk(dru_pkg::OFF_MODE, 32'h0000_4000);
		reg_wr(dru_pkg::OFF_MODE, 32'h0000_0000);
		lat <= 4'h0;
	endtask

	task automatic give_verdict;
		$display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Main sequence: reset, then each scenario in turn.
	initial
	begin
		nrst = 1'b0;
		addr = 5'h00;
		wr_data = 32'h0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		xfer_req = 1'b0;
		size_err = 1'b0;
		fault_in = 1'b0;
		lat = 4'h0;
		repeat (20) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		t_regs();
		t_unaligned();
		t_update();
		t_block();
		t_events();
		t_wrap();
		t_burst();
		give_verdict();
	end

	// Watchdog sized well beyond the few hundred cycles the scenarios need.
	initial
	begin
		#1000000;
		error_cnt++;
		give_verdict();
	end
endmodule
